// >>> tco_pkg.sv
// Shared constants and state types for the timer compare-output block
package tco_pkg;

  localparam int unsigned COUNT_W      = 8;
  localparam int unsigned MODE_W       = 3;
  localparam int unsigned ACTION_W     = 2;
  localparam int unsigned CLKSEL_W     = 3;

  localparam logic [COUNT_W-1:0]  COUNT_MAX    = 8'hFF;
  localparam logic [COUNT_W-1:0]  COUNT_BOTTOM = 8'h00;
  localparam logic [COUNT_W-1:0]  COUNT_STEP   = 8'h01;
  localparam logic [COUNT_W-1:0]  COUNT_RESET  = 8'h00;

  localparam logic [MODE_W-1:0]   MODE_NORMAL  = 3'h0;
  localparam logic [MODE_W-1:0]   MODE_CLEAR_ON_MATCH = 3'h2;

  localparam logic [ACTION_W-1:0] ACT_NONE     = 2'h0;
  localparam logic [ACTION_W-1:0] ACT_TOGGLE   = 2'h1;
  localparam logic [ACTION_W-1:0] ACT_CLEAR    = 2'h2;
  localparam logic [ACTION_W-1:0] ACT_SET      = 2'h3;

  localparam logic [CLKSEL_W-1:0] CLKSEL_STOPPED = 3'h0;

  localparam logic STATE_RESET = 1'b0;
  localparam logic FLAG_RESET  = 1'b0;

  typedef struct packed {
    logic state;
    logic pin_out;
    logic pin_oe;
  } tco_out_t;

  typedef struct packed {
    logic [COUNT_W-1:0] count;
    logic               overflow_flag;
    logic               compare_flag_a;
    logic               compare_flag_b;
    logic               block;
  } tco_timer_t;

endpackage : tco_pkg

// >>> tco_compare_output.sv
// One compare output channel: output state and port pin override
`timescale 1ns/1ns
module tco_compare_output (
  input  wire logic                         i_clk,
  input  wire logic                         i_rst_n,
  input  wire logic                         i_ce,
  input  wire logic                         i_event,
  input  wire logic [tco_pkg::ACTION_W-1:0] i_action,
  input  wire logic                         i_port_value,
  input  wire logic                         i_direction,
  output logic                              o_state,
  output logic                              o_pin_out,
  output logic                              o_pin_oe
);

  tco_pkg::tco_out_t s_q;
  tco_pkg::tco_out_t s_d;

  always_comb begin
    s_d = s_q;
    if (i_event) begin
      unique case (i_action)
        tco_pkg::ACT_NONE:   s_d.state = s_q.state;
        tco_pkg::ACT_TOGGLE: s_d.state = ~s_q.state;
        tco_pkg::ACT_CLEAR:  s_d.state = 1'b0;
        tco_pkg::ACT_SET:    s_d.state = 1'b1;
      endcase
    end
    // Override does not look at the waveform mode
    s_d.pin_out = (i_action != tco_pkg::ACT_NONE) ? s_d.state
                                                   : i_port_value;
    s_d.pin_oe  = i_direction;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q.state   <= tco_pkg::STATE_RESET;
      s_q.pin_out <= 1'b0;
      s_q.pin_oe  <= 1'b0;
    end else if (i_ce) begin
      s_q <= s_d;
    end
  end

  assign o_state   = s_q.state;
  assign o_pin_out = s_q.pin_out;
  assign o_pin_oe  = s_q.pin_oe;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  property p_override;
    i_ce && (i_action != tco_pkg::ACT_NONE) |=> o_pin_out == o_state;
  endproperty
  a_override: assert property (p_override)
    else $error("Pin does not follow output state under override");

  property p_port;
    i_ce && (i_action == tco_pkg::ACT_NONE)
      |=> o_pin_out == $past(i_port_value);
  endproperty
  a_port: assert property (p_port)
    else $error("Pin does not follow port value without override");

  property p_direction;
    i_ce |=> o_pin_oe == $past(i_direction);
  endproperty
  a_direction: assert property (p_direction)
    else $error("Pin enable does not follow direction bit");

  property p_no_action;
    i_ce && (i_action == tco_pkg::ACT_NONE) |=> $stable(o_state);
  endproperty
  a_no_action: assert property (p_no_action)
    else $error("Output state changed with no action selected");

  property p_toggle;
    i_ce && i_event && (i_action == tco_pkg::ACT_TOGGLE)
      |=> o_state != $past(o_state);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("Toggle action did not invert output state");

  property p_set_clear;
    i_ce && i_event && i_action[1] |=> o_state == $past(i_action[0]);
  endproperty
  a_set_clear: assert property (p_set_clear)
    else $error("Set or clear action gave wrong output state");

endmodule : tco_compare_output

// >>> tco_timer.sv
// Timer counter with normal and clear-on-match modes and two compare outputs
`timescale 1ns/1ns
module tco_timer (
  input  wire logic                         i_clk,
  input  wire logic                         i_rst_n,
  input  wire logic                         i_ce,
  input  wire logic                         i_timer_tick,
  input  wire logic [tco_pkg::CLKSEL_W-1:0] i_clock_source_select,
  input  wire logic [tco_pkg::MODE_W-1:0]   i_waveform_mode_select,
  input  wire logic [tco_pkg::ACTION_W-1:0] i_compare_output_action_a,
  input  wire logic [tco_pkg::ACTION_W-1:0] i_compare_output_action_b,
  input  wire logic [tco_pkg::COUNT_W-1:0]  i_compare_value_a,
  input  wire logic [tco_pkg::COUNT_W-1:0]  i_compare_value_b,
  input  wire logic                         i_count_wr,
  input  wire logic [tco_pkg::COUNT_W-1:0]  i_count_wdata,
  input  wire logic                         i_force_compare_strobe_a,
  input  wire logic                         i_force_compare_strobe_b,
  input  wire logic                         i_overflow_int_ack,
  input  wire logic                         i_compare_int_ack_a,
  input  wire logic                         i_compare_int_ack_b,
  input  wire logic                         i_overflow_flag_clr,
  input  wire logic                         i_compare_flag_clr_a,
  input  wire logic                         i_compare_flag_clr_b,
  input  wire logic                         i_port_value_a,
  input  wire logic                         i_port_value_b,
  input  wire logic                         i_output_pin_direction_bit_a,
  input  wire logic                         i_output_pin_direction_bit_b,
  output logic [tco_pkg::COUNT_W-1:0]       o_count_value,
  output logic                              o_overflow_flag,
  output logic                              o_compare_flag_a,
  output logic                              o_compare_flag_b,
  output logic                              o_compare_output_state_a,
  output logic                              o_compare_output_state_b,
  output logic                              o_pin_out_a,
  output logic                              o_pin_oe_a,
  output logic                              o_pin_out_b,
  output logic                              o_pin_oe_b
);

  tco_pkg::tco_timer_t t_q;
  tco_pkg::tco_timer_t t_d;

  logic tick;
  logic non_pwm;
  logic clear_mode;
  logic match_a;
  logic match_b;
  logic event_a;
  logic event_b;
  logic ovf_set;

  // Compare of the running count against a live compare value
  function automatic logic hits(
    input logic [tco_pkg::COUNT_W-1:0] cnt,
    input logic [tco_pkg::COUNT_W-1:0] ref_value
  );
    hits = (cnt == ref_value);
  endfunction : hits

  // Flag update where a new event wins over any clear
  function automatic logic flag_next(
    input logic cur,
    input logic set,
    input logic clr
  );
    flag_next = set | (cur & ~clr);
  endfunction : flag_next

  always_comb begin
    tick       = i_timer_tick
               && (i_clock_source_select != tco_pkg::CLKSEL_STOPPED);
    clear_mode = (i_waveform_mode_select == tco_pkg::MODE_CLEAR_ON_MATCH);
    non_pwm    = (i_waveform_mode_select == tco_pkg::MODE_NORMAL)
               || clear_mode;
    // Compare value A is used as written, no shadow copy
    match_a    = tick && !t_q.block && !i_count_wr
               && hits(t_q.count, i_compare_value_a);
    match_b    = tick && !t_q.block && !i_count_wr
               && hits(t_q.count, i_compare_value_b);
    event_a    = match_a
               || (non_pwm && i_force_compare_strobe_a);
    event_b    = match_b
               || (non_pwm && i_force_compare_strobe_b);
    ovf_set    = tick && !i_count_wr
               && hits(t_q.count, tco_pkg::COUNT_MAX)
               && !(clear_mode && match_a);
  end

  always_comb begin
    t_d = t_q;
    // Counter next value ignores the output actions
    if (i_count_wr) begin
      t_d.count = i_count_wdata;
    end else if (tick) begin
      if (clear_mode && match_a) begin
        t_d.count = tco_pkg::COUNT_BOTTOM;
      end else begin
        t_d.count = t_q.count + tco_pkg::COUNT_STEP;
      end
    end
    // A write holds off matches until a timer clock has passed
    if (i_count_wr) begin
      t_d.block = 1'b1;
    end else if (tick) begin
      t_d.block = 1'b0;
    end
    t_d.overflow_flag  = flag_next(t_q.overflow_flag, ovf_set,
      i_overflow_int_ack | i_overflow_flag_clr);
    // Forced compares never reach the flags
    t_d.compare_flag_a = flag_next(t_q.compare_flag_a, match_a,
      i_compare_int_ack_a | i_compare_flag_clr_a);
    t_d.compare_flag_b = flag_next(t_q.compare_flag_b, match_b,
      i_compare_int_ack_b | i_compare_flag_clr_b);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      t_q.count          <= tco_pkg::COUNT_RESET;
      t_q.overflow_flag  <= tco_pkg::FLAG_RESET;
      t_q.compare_flag_a <= tco_pkg::FLAG_RESET;
      t_q.compare_flag_b <= tco_pkg::FLAG_RESET;
      t_q.block          <= 1'b0;
    end else if (i_ce) begin
      t_q <= t_d;
    end
  end

  assign o_count_value    = t_q.count;
  assign o_overflow_flag  = t_q.overflow_flag;
  assign o_compare_flag_a = t_q.compare_flag_a;
  assign o_compare_flag_b = t_q.compare_flag_b;

  // Action is read live at the event, so a new setting counts at once
  tco_compare_output u_out_a (
    .i_clk        (i_clk),
    .i_rst_n      (i_rst_n),
    .i_ce         (i_ce),
    .i_event      (event_a),
    .i_action     (i_compare_output_action_a),
    .i_port_value (i_port_value_a),
    .i_direction  (i_output_pin_direction_bit_a),
    .o_state      (o_compare_output_state_a),
    .o_pin_out    (o_pin_out_a),
    .o_pin_oe     (o_pin_oe_a)
  );

  tco_compare_output u_out_b (
    .i_clk        (i_clk),
    .i_rst_n      (i_rst_n),
    .i_ce         (i_ce),
    .i_event      (event_b),
    .i_action     (i_compare_output_action_b),
    .i_port_value (i_port_value_b),
    .i_direction  (i_output_pin_direction_bit_b),
    .o_state      (o_compare_output_state_b),
    .o_pin_out    (o_pin_out_b),
    .o_pin_oe     (o_pin_oe_b)
  );

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_normal_step;
    i_ce && tick && !i_count_wr
      && (i_waveform_mode_select == tco_pkg::MODE_NORMAL);
  endsequence

  sequence s_write_then_idle;
    i_ce && i_count_wr && !o_compare_flag_a
      ##1 (!tick && !i_count_wr)[*5]
      ##1 (i_ce && tick && !i_count_wr);
  endsequence

  property p_count_up;
    s_normal_step |=> o_count_value
      == $past(o_count_value) + tco_pkg::COUNT_STEP;
  endproperty
  a_count_up: assert property (p_count_up)
    else $error("Normal mode did not count up by one");

  property p_overflow;
    s_normal_step ##0 (o_count_value == tco_pkg::COUNT_MAX)
      |=> o_overflow_flag && (o_count_value == tco_pkg::COUNT_BOTTOM);
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("Overflow flag not set as counter wrapped");

  property p_overflow_clear;
    i_ce && i_overflow_int_ack && !ovf_set |=> !o_overflow_flag;
  endproperty
  a_overflow_clear: assert property (p_overflow_clear)
    else $error("Overflow flag not cleared on interrupt");

  property p_write;
    i_ce && i_count_wr |=> o_count_value == $past(i_count_wdata);
  endproperty
  a_write: assert property (p_write)
    else $error("Counter write not taken");

  property p_top_clear;
    i_ce && tick && !i_count_wr && !t_q.block && clear_mode
      && (o_count_value == i_compare_value_a)
      |=> (o_count_value == tco_pkg::COUNT_BOTTOM) && o_compare_flag_a;
  endproperty
  a_top_clear: assert property (p_top_clear)
    else $error("Clear-on-match did not clear counter and set flag");

  property p_zero_top_toggle;
    i_ce && tick && !i_count_wr && !t_q.block && clear_mode
      && (i_compare_value_a == tco_pkg::COUNT_BOTTOM)
      && (o_count_value == tco_pkg::COUNT_BOTTOM)
      && (i_compare_output_action_a == tco_pkg::ACT_TOGGLE)
      |=> o_compare_output_state_a != $past(o_compare_output_state_a);
  endproperty
  a_zero_top_toggle: assert property (p_zero_top_toggle)
    else $error("Output A did not toggle on each timer clock");

  property p_match_flag;
    i_ce && match_b |=> o_compare_flag_b;
  endproperty
  a_match_flag: assert property (p_match_flag)
    else $error("Compare flag B not set after match");

  property p_block;
    s_write_then_idle |=> !o_compare_flag_a;
  endproperty
  a_block: assert property (p_block)
    else $error("Compare flag set while matches are blocked");

  property p_force_only_output;
    i_ce && i_force_compare_strobe_a && !tick && !i_count_wr
      && !o_compare_flag_a
      |=> !o_compare_flag_a && $stable(o_count_value);
  endproperty
  a_force_only_output: assert property (p_force_only_output)
    else $error("Forced compare touched flag or counter");

  property p_force_now;
    i_ce && i_force_compare_strobe_a && non_pwm
      && (i_compare_output_action_a == tco_pkg::ACT_SET)
      |=> o_compare_output_state_a;
  endproperty
  a_force_now: assert property (p_force_now)
    else $error("Forced set did not reach output state at once");

  property p_stopped;
    i_ce && (i_clock_source_select == tco_pkg::CLKSEL_STOPPED)
      && !i_count_wr |=> $stable(o_count_value);
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("Counter moved with clock source stopped");

  property p_late_top;
    i_ce && tick && !i_count_wr && clear_mode
      && (o_count_value > i_compare_value_a)
      |=> o_count_value == $past(o_count_value) + tco_pkg::COUNT_STEP;
  endproperty
  a_late_top: assert property (p_late_top)
    else $error("Counter cleared below a passed compare value");

  property p_overflow_hold;
    i_ce && o_overflow_flag && !i_overflow_int_ack && !i_overflow_flag_clr
      |=> o_overflow_flag;
  endproperty
  a_overflow_hold: assert property (p_overflow_hold)
    else $error("Overflow flag cleared by counting");

  property p_flag_hold;
    i_ce && o_compare_flag_a && !i_compare_int_ack_a && !i_compare_flag_clr_a
      |=> o_compare_flag_a;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("Compare flag A lost without a clear");

  property p_top_step;
    i_ce && tick && !i_count_wr && clear_mode
      && (o_count_value < i_compare_value_a)
      |=> o_count_value == $past(o_count_value) + tco_pkg::COUNT_STEP;
  endproperty
  a_top_step: assert property (p_top_step)
    else $error("Counter did not step below the top");

  property p_stopped_flag;
    i_ce && (i_clock_source_select == tco_pkg::CLKSEL_STOPPED)
      && !o_compare_flag_b |=> !o_compare_flag_b;
  endproperty
  a_stopped_flag: assert property (p_stopped_flag)
    else $error("Compare flag B set with clock source stopped");

endmodule : tco_timer

// >>> tco_pin_model.sv
// Port pin model: resolves the pad level from drive enable and value
`timescale 1ns/1ns
module tco_pin_model (
  input  wire logic i_clk,
  input  wire logic i_pin_out,
  input  wire logic i_pin_oe,
  output logic      o_level
);
  logic last_q;
  always_ff @(posedge i_clk) begin
    last_q <= (o_level === 1'b1);
  end
  // Undriven pad shows the inverse of its last level
  assign o_level = i_pin_oe ? i_pin_out : ~last_q;
endmodule : tco_pin_model

// >>> tb.sv
// Self-checking testbench for the timer compare-output block
`timescale 1ns/1ns
module tb;
  logic       clk = 1'b0;
  logic       rst_n, ce, tick, wr, fa, fb, ovf_ack, ack_a, ack_b;
  logic       ovf_clr, clr_a, clr_b, port_a, port_b, dir_a, dir_b;
  logic [2:0] sel, mode;
  logic [1:0] act_a, act_b;
  logic [7:0] ocr_a, ocr_b, wdata, cnt;
  logic       ovf, cf_a, cf_b, st_a, st_b, po_a, oe_a, po_b, oe_b, lvl_a;
  int         mismatches = 0;
  int         comparisons = 0;

  tco_timer uut (
    .i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_timer_tick(tick),
    .i_clock_source_select(sel), .i_waveform_mode_select(mode),
    .i_compare_output_action_a(act_a), .i_compare_output_action_b(act_b),
    .i_compare_value_a(ocr_a), .i_compare_value_b(ocr_b),
    .i_count_wr(wr), .i_count_wdata(wdata),
    .i_force_compare_strobe_a(fa), .i_force_compare_strobe_b(fb),
    .i_overflow_int_ack(ovf_ack), .i_compare_int_ack_a(ack_a),
    .i_compare_int_ack_b(ack_b), .i_overflow_flag_clr(ovf_clr),
    .i_compare_flag_clr_a(clr_a), .i_compare_flag_clr_b(clr_b),
    .i_port_value_a(port_a), .i_port_value_b(port_b),
    .i_output_pin_direction_bit_a(dir_a),
    .i_output_pin_direction_bit_b(dir_b),
    .o_count_value(cnt), .o_overflow_flag(ovf),
    .o_compare_flag_a(cf_a), .o_compare_flag_b(cf_b),
    .o_compare_output_state_a(st_a), .o_compare_output_state_b(st_b),
    .o_pin_out_a(po_a), .o_pin_oe_a(oe_a),
    .o_pin_out_b(po_b), .o_pin_oe_b(oe_b)
  );

  tco_pin_model pin_a (
    .i_clk(clk), .i_pin_out(po_a), .i_pin_oe(oe_a), .o_level(lvl_a)
  );

  always #5 clk = ~clk;

  task automatic summarize;
    if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string msg);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask : chk

  task automatic ticks(input int n);
    @(posedge clk); tick <= 1'b1;
    repeat (n) @(posedge clk);
    tick <= 1'b0; #1;
  endtask : ticks

  task automatic wr_cnt(input logic [7:0] v);
    @(posedge clk); wr <= 1'b1; wdata <= v;
    @(posedge clk); wr <= 1'b0; #1;
  endtask : wr_cnt

  task automatic frc(input logic a, input logic b);
    @(posedge clk); fa <= a; fb <= b;
    @(posedge clk); fa <= 1'b0; fb <= 1'b0; #1;
  endtask : frc

  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  task automatic t_force;
    logic [1:0] acts [4];
    logic       exps [4];
    acts = '{2'h3, 2'h2, 2'h1, 2'h0};
    exps = '{1'b1, 1'b0, 1'b1, 1'b1};
    @(posedge clk); sel <= 3'h0; dir_a <= 1'b0; port_a <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk); act_a <= acts[i];
      frc(1'b1, 1'b0);
      chk(st_a, exps[i], "forced output state a");
      chk(oe_a, 1'b0, "pin drive while input");
      chk(cf_a, 1'b0, "flag set by force");
      chk(cnt, 8'h00, "counter moved by force");
    end
    chk(po_a, 1'b0, "port value with action zero");
    @(posedge clk); act_a <= 2'h3; dir_a <= 1'b1;
    settle;
    chk(po_a, 1'b1, "override shows preset state");
    chk(oe_a, 1'b1, "pin drive when output");
    chk(lvl_a, 1'b1, "pad level");
    @(posedge clk); act_b <= 2'h3;
    frc(1'b0, 1'b1);
    chk(st_b, 1'b1, "forced output state b");
  endtask : t_force

  task automatic t_normal;
    @(posedge clk); mode <= 3'h0; sel <= 3'h1;
    wr_cnt(8'hFE);
    chk(cnt, 8'hFE, "counter write");
    ticks(1);
    chk(cnt, 8'hFF, "count to max");
    chk(ovf, 1'b0, "early overflow");
    ticks(1);
    chk(cnt, 8'h00, "wrap to zero");
    chk(ovf, 1'b1, "overflow at zero");
    ticks(1);
    chk(ovf, 1'b1, "overflow held while counting");
    @(posedge clk); ovf_ack <= 1'b1;
    @(posedge clk); ovf_ack <= 1'b0; #1;
    chk(ovf, 1'b0, "overflow cleared by interrupt");
  endtask : t_normal

  task automatic t_ctc;
    logic s;
    @(posedge clk); mode <= 3'h2; act_a <= 2'h1; ocr_a <= 8'h03;
    wr_cnt(8'h00);
    ticks(3);
    chk(cnt, 8'h03, "count up to top");
    chk(cf_a, 1'b0, "flag before match");
    ticks(1);
    chk(cnt, 8'h00, "clear on match");
    chk(cf_a, 1'b1, "flag at top");
    chk(st_a, 1'b0, "toggle on match");
    chk(po_a, 1'b0, "override in mode 2");
    @(posedge clk); ack_a <= 1'b1;
    @(posedge clk); ack_a <= 1'b0; #1;
    chk(cf_a, 1'b0, "compare flag cleared");
    @(posedge clk); ocr_a <= 8'h00;
    s = 1'b0;
    for (int i = 0; i < 4; i++) begin
      ticks(1);
      s = ~s;
      chk(st_a, s, "toggle each timer clock");
      chk(cnt, 8'h00, "count held at zero top");
    end
  endtask : t_ctc

  task automatic t_block;
    @(posedge clk); sel <= 3'h0; ocr_a <= 8'h09; clr_a <= 1'b1;
    @(posedge clk); clr_a <= 1'b0; #1;
    chk(cf_a, 1'b0, "flag write-one clear");
    wr_cnt(8'h09);
    ticks(2);
    chk(cnt, 8'h09, "stopped counter written");
    @(posedge clk); sel <= 3'h1;
    ticks(1);
    chk(cnt, 8'h0A, "match blocked after write");
    chk(cf_a, 1'b0, "no flag after write");
    @(posedge clk); ce <= 1'b0;
    ticks(1);
    chk(cnt, 8'h0A, "frozen while disabled");
    @(posedge clk); ce <= 1'b1;
  endtask : t_block

  task automatic t_wrap;
    @(posedge clk); ocr_a <= 8'h05;
    ticks(246);
    chk(cnt, 8'h00, "low top wraps through max");
    chk(cf_a, 1'b0, "missed match");
    chk(ovf, 1'b1, "overflow at wrap");
    ticks(5);
    chk(cnt, 8'h05, "reach top after wrap");
    ticks(1);
    chk(cnt, 8'h00, "clear after wrap");
    chk(cf_a, 1'b1, "flag after wrap");
    chk(cf_b, 1'b1, "flag b after passing its match");
    chk(po_b, 1'b1, "pin b shows output state b");
    chk(oe_b, 1'b1, "pin b drive when output");
    @(posedge clk); ovf_clr <= 1'b1; ack_b <= 1'b1;
    @(posedge clk); ovf_clr <= 1'b0; ack_b <= 1'b0; #1;
    chk(ovf, 1'b0, "overflow write-one clear");
    chk(cf_b, 1'b0, "compare flag b cleared by interrupt");
  endtask : t_wrap

  initial begin
    rst_n = 1'b0; ce = 1'b1; tick = 1'b0; wr = 1'b0; fa = 1'b0;
    fb = 1'b0; ovf_ack = 1'b0; ack_a = 1'b0; ack_b = 1'b0;
    ovf_clr = 1'b0; clr_a = 1'b0; clr_b = 1'b0; port_a = 1'b1;
    port_b = 1'b0; dir_a = 1'b0; dir_b = 1'b1; sel = 3'h0;
    mode = 3'h0; act_a = 2'h0; act_b = 2'h0; ocr_a = 8'h80;
    ocr_b = 8'h80; wdata = 8'h00;
    repeat (12) @(posedge clk);
    #1;
    chk(st_a, 1'b0, "state a in reset");
    chk(st_b, 1'b0, "state b in reset");
    chk(cnt, 8'h00, "count in reset");
    @(posedge clk); rst_n <= 1'b1;
    t_force();
    t_normal();
    t_ctc();
    t_block();
    t_wrap();
    summarize();
  end

  initial begin
    #100000;
    mismatches++;
    summarize();
  end
endmodule : tb
